// file: dv/rwcr_properties.sv
// port assertions for the wake configuration bank
// bound to rwcr_regs; one clock, sync reset
`timescale 1ns/1ps
module rwcr_properties
  import rwcr_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // register port
  input wire logic [9:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regRdData,
  // settings and status
  input wire logic [23:0] carrierWord,
  input wire logic [11:0] rateCode,
  input wire logic [11:0] toneOffsetCode,
  input wire logic [7:0]  correlatorBandwidth,
  input wire logic [7:0]  postFilterBandwidth,
  input wire logic [5:0]  rxLoopSetting,
  input wire logic [1:0]  correlatorPhase,
  input wire logic        radioOn,
  input wire logic        radioOffState,
  input wire logic        wakeLimitIrq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_wr(logic [9:0] a);
    regWrite && regAddr == a;
  endsequence
  property p_rd; !$past(regRead) |-> regRdData == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data out of slot");
  property p_car; s_wr(OFF_CARRIER_HI) |=> carrierWord[23:16] == $past(regWrData); endproperty
  a_car: assert property (p_car) else $error("carrier top byte");
  property p_rate;
    s_wr(OFF_RATE_DEV_HI) |=> {toneOffsetCode[11:8], rateCode[11:8]} == $past(regWrData);
  endproperty
  a_rate: assert property (p_rate) else $error("rate or deviation nibble");
  property p_bw; s_wr(OFF_CORR_BW) |-> ##2 correlatorBandwidth == $past(regWrData, 2); endproperty
  a_bw: assert property (p_bw) else $error("correlator bandwidth");
  // zero is refused, so only nonzero data must be followed
  property p_post;
    regWrite && regAddr == OFF_POST_FILTER && regWrData != 8'h00
      |-> ##2 postFilterBandwidth == $past(regWrData, 2);
  endproperty
  a_post: assert property (p_post) else $error("post filter");
  property p_ph;
    s_wr(OFF_LOOP_PHASE) |-> ##2 {rxLoopSetting, correlatorPhase} == $past(regWrData, 2);
  endproperty
  a_ph: assert property (p_ph) else $error("loop and phase fields");
  property p_irq; wakeLimitIrq |-> radioOffState ##1 !wakeLimitIrq; endproperty
  a_irq: assert property (p_irq) else $error("wake limit pulse");
  property p_ex; !(radioOn && radioOffState); endproperty
  a_ex: assert property (p_ex) else $error("listening while off");
endmodule // rwcr_properties

// file: dv/rwcr_radio_model.sv
// radio-side pin model: wake timer, preamble, signal level
// pins are async to mclk, but the model moves them just after the rising edge
`timescale 1ns/1ps
module rwcr_radio_model
(
  // clock
  input wire logic mclk,
  // radio pins
  output logic     wakeTimerPin,
  output logic     preamblePin,
  output logic     levelAbovePin
);
  initial
  begin
    wakeTimerPin = 1'b0;
    preamblePin = 1'b0;
    levelAbovePin = 1'b0;
  end
  // two cycles high so the synchroniser cannot miss the edge
  task automatic wake();
    @(posedge mclk);
    wakeTimerPin <= 1'b1;
    repeat (2) @(posedge mclk);
    wakeTimerPin <= 1'b0;
  endtask
  task automatic setPins(input logic p, input logic l);
    @(posedge mclk);
    preamblePin <= p;
    levelAbovePin <= l;
  endtask
endmodule // rwcr_radio_model

// file: dv/tb_radio_wake_config_regs.sv
// self-checking bench for the wake configuration bank
// assumes a two-cycle wake timer unit to keep listens short
`timescale 1ns/1ps
module tb_radio_wake_config_regs
  import rwcr_pkg::*;
;
  logic        mclk, reset, regWrite, regRead, radioOn, radioOffState, wakeLimitIrq;
  logic        wakeTimerPin, preamblePin, levelAbovePin;
  logic [9:0]  regAddr;
  logic [7:0]  regWrData, regRdData, correlatorBandwidth, postFilterBandwidth, wakeLevelLimit;
  logic [23:0] carrierWord;
  logic [11:0] rateCode, toneOffsetCode;
  logic [5:0]  rxLoopSetting;
  logic [1:0]  correlatorPhase;
  int          numErrors = 0, nChecks = 0, cyc;
  // loop field assumes lookup mode 1, so nonzero is legal; low bytes precede 0x10d
  logic [17:0] rows [13] = '{{10'h105, 8'ha5}, {10'h106, 8'h02}, {10'h107, 8'h01},
    {10'h108, 8'h3c}, {10'h109, 8'h11}, {10'h10a, 8'h22}, {10'h10b, 8'h33}, {10'h10c, 8'h44},
    {10'h10e, 8'h66}, {10'h10d, 8'h5b}, {10'h10f, 8'h77}, {10'h110, 8'h88}, {10'h112, 8'hfd}};
  rwcr_regs #(.UNIT_CYCLES(2)) uut (.mclk, .reset, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .wakeTimerPin, .preamblePin, .levelAbovePin, .carrierWord, .rateCode,
    .toneOffsetCode, .correlatorBandwidth, .postFilterBandwidth, .rxLoopSetting,
    .correlatorPhase, .wakeLevelLimit, .radioOn, .radioOffState, .wakeLimitIrq);
  rwcr_radio_model radio (.mclk, .wakeTimerPin, .preamblePin, .levelAbovePin);
  task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      numErrors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic printVerdict();
    if (numErrors == 0 && nChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    // strobe lasts exactly one cycle
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    chk("read data", {16'h0000, regRdData}, {16'h0000, e});
  endtask
  task automatic waitFor(input int sel, input logic lvl);
    // step off the edge so outputs have settled
    #1;
    for (cyc = 0; cyc < 100; cyc++)
    begin
      if ((sel == 0 ? radioOn : sel == 1 ? radioOffState : wakeLimitIrq) === lvl)
        return;
      @(posedge mclk) #1;
    end
    numErrors++;
    printVerdict();
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial
  begin
    reset = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 10'h000;
    regWrData = 8'h00;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    rd(OFF_TICK_DIV, 8'h33);
    rd(OFF_POST_FILTER, 8'h01);
    foreach (rows[i])
    begin
      wr(rows[i][17:8], rows[i][7:0]);
      rd(rows[i][17:8], rows[i][7:0]);
    end
    @(posedge mclk) #1;
    chk("carrier", carrierWord, 24'h332211);
    chk("rate", {rateCode, toneOffsetCode}, 24'hb44566);
    chk("bw", {correlatorBandwidth, wakeLevelLimit}, 24'h773c);
    chk("phase", {postFilterBandwidth, rxLoopSetting, correlatorPhase}, 24'h88fd);
    wr(OFF_POST_FILTER, 8'h00);
    wr(OFF_CARRIER_LO, 8'h99);
    rd(10'h1ff, 8'h00);
    chk("hold", {postFilterBandwidth, carrierWord[15:0]}, 24'h882211);
    wr(OFF_WAKE_CTRL, 8'h01);
    rd(OFF_WAKE_CNT_LO, 8'h00);
    radio.wake();
    waitFor(0, 1'b1);
    waitFor(0, 1'b0);
    chk("dwell", 24'(cyc inside {[4:5]}), 24'h1);
    wr(OFF_LISTEN_PERIOD, 8'h20);
    rd(OFF_WAKE_CNT_LO, 8'h01);
    radio.wake();
    waitFor(0, 1'b1);
    radio.setPins(1'b1, 1'b0);
    waitFor(1, 1'b1);
    radio.setPins(1'b0, 1'b0);
    wr(OFF_WAKE_CTRL, 8'h00);
    rd(OFF_LISTEN_PERIOD, 8'h20);
    waitFor(1, 1'b0);
    wr(OFF_WAKE_CTRL, 8'h03);
    radio.wake();
    waitFor(0, 1'b1);
    radio.setPins(1'b0, 1'b1);
    waitFor(1, 1'b1);
    rd(OFF_WAKE_CTRL, 8'h02);
    radio.setPins(1'b0, 1'b0);
    wr(OFF_WAKE_CTRL, 8'h00);
    waitFor(1, 1'b0);
    wr(OFF_WAKE_CNT_HI, 8'h00);
    wr(OFF_WAKE_CNT_LO, 8'h00);
    rd(OFF_WAKE_CNT_LO, 8'h00);
    wr(OFF_WAKE_CNT_LO, 8'hff);
    wr(OFF_WAKE_LIM_HI, 8'h01);
    rd(OFF_WAKE_LIM_HI, 8'h01);
    radio.wake();
    repeat (6) @(posedge mclk) #1;
    chk("below limit", radioOffState, 24'h0);
    radio.wake();
    waitFor(2, 1'b1);
    rd(OFF_WAKE_CNT_HI, 8'h01);
    printVerdict();
  end
endmodule // tb_radio_wake_config_regs
bind rwcr_regs rwcr_properties chkProps (.mclk, .reset, .regAddr, .regWrData, .regWrite,
  .regRead, .regRdData, .carrierWord, .rateCode, .toneOffsetCode, .correlatorBandwidth,
  .postFilterBandwidth, .rxLoopSetting, .correlatorPhase, .radioOn, .radioOffState,
  .wakeLimitIrq);

// file: hdl/rwcr_pkg.sv
// package for the radio wake configuration register bank
// assumes byte-wide registers reached over a plain strobe port
package rwcr_pkg;
  localparam int          ADDR_W            = 10;
  localparam int          DATA_W            = 8;
  // register offsets
  localparam logic [9:0]  OFF_WAKE_CNT_LO   = 10'h102;
  localparam logic [9:0]  OFF_WAKE_CNT_HI   = 10'h103;
  localparam logic [9:0]  OFF_WAKE_LIM_LO   = 10'h104;
  localparam logic [9:0]  OFF_WAKE_LIM_HI   = 10'h105;
  localparam logic [9:0]  OFF_LISTEN_PERIOD = 10'h106;
  localparam logic [9:0]  OFF_TICK_DIV      = 10'h107;
  localparam logic [9:0]  OFF_LEVEL_LIMIT   = 10'h108;
  localparam logic [9:0]  OFF_CARRIER_LO    = 10'h109;
  localparam logic [9:0]  OFF_CARRIER_MID   = 10'h10a;
  localparam logic [9:0]  OFF_CARRIER_HI    = 10'h10b;
  localparam logic [9:0]  OFF_RATE_LO       = 10'h10c;
  localparam logic [9:0]  OFF_RATE_DEV_HI   = 10'h10d;
  localparam logic [9:0]  OFF_DEV_LO        = 10'h10e;
  localparam logic [9:0]  OFF_CORR_BW       = 10'h10f;
  localparam logic [9:0]  OFF_POST_FILTER   = 10'h110;
  localparam logic [9:0]  OFF_SPARE         = 10'h111;
  localparam logic [9:0]  OFF_LOOP_PHASE    = 10'h112;
  localparam logic [9:0]  OFF_WAKE_CTRL     = 10'h11f;
  // field positions
  localparam int          RATE_HI_LSB       = 0;
  localparam int          DEV_HI_LSB        = 4;
  localparam int          PHASE_LSB         = 0;
  localparam int          LOOP_LSB          = 2;
  localparam int          CTRL_SMART_BIT    = 0;
  localparam int          CTRL_LEVEL_BIT    = 1;
  // reset values
  localparam logic [7:0]  RST_BYTE          = 8'h00;
  localparam logic [7:0]  RST_TICK_DIV      = 8'h33;
  localparam logic [7:0]  RST_POST_FILTER   = 8'h01;
  // timing: tick = 128 * divider periods of the 6.5 MHz reference
  localparam int          TICK_MULT         = 128;
  localparam int          REF_KHZ           = 6500;
  localparam int          MCLK_KHZ          = 10000;
  // one wake-timer prescale unit in mclk cycles, rounded down, min 1
  localparam int          UNIT_CYC_RAW      = (TICK_MULT * MCLK_KHZ) / REF_KHZ;
  localparam int          UNIT_CYC          = (UNIT_CYC_RAW < 1) ? 1 : UNIT_CYC_RAW;
  localparam int          LEVEL_OFFSET_DBM  = 107;
  localparam int          CARRIER_FRAC_BITS = 16;
  localparam int          RATE_STEP_BPS     = 100;
  localparam int          POST_FILTER_STEP  = 2;

  typedef enum logic [1:0] {
    RW_SLEEP  = 2'b00,
    RW_LISTEN = 2'b01,
    RW_OFF    = 2'b10
  } rwcr_state_t;
endpackage

// file: hdl/rwcr_regs.sv
// radio wake configuration register bank with smart-wake listen sequencer
// assumes host strobes on mclk; wake timer, preamble and level inputs are off-domain pins
//
// What this block does
// [RQ1] limit high byte at 0x105, low at 0x104
// [RQ2] smart wake: radio on, listen, else sleep
// [RQ3] tick is 128*divider/6.5MHz; dwell counts ticks
// [RQ4] level limit in dBm is value minus 107
// [RQ5] 24-bit carrier word, low byte first
// [RQ6] 12-bit rate code, high nibble [3:0]
// [RQ7] 12-bit deviation, high nibble [7:4]
// [RQ8] correlator bandwidth from its byte
// [RQ9] post filter is 2 kHz steps, 1..255
// [RQ10] host zeroes loop setting in modes 0/2
// [RQ11] correlator phase from bits [1:0]
// [RQ12] count wakes, beyond limit go off
// [RQ13] wake count writable to zero
// [RQ14] bytes read back (0x102/0x103 read the live wake count, 0x11f live status instead); carrier and rate/deviation fields apply together
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module rwcr_regs
  import rwcr_pkg::*;
#(
  parameter int UNIT_CYCLES = UNIT_CYC
)
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  // register port
  input  wire logic [ADDR_W-1:0]  regAddr,
  input  wire logic [DATA_W-1:0]  regWrData,
  input  wire logic               regWrite,
  input  wire logic               regRead,
  output logic      [DATA_W-1:0]  regRdData,
  // radio side pins
  input  wire logic               wakeTimerPin,
  input  wire logic               preamblePin,
  input  wire logic               levelAbovePin,
  // applied settings
  output logic      [23:0]        carrierWord,
  output logic      [11:0]        rateCode,
  output logic      [11:0]        toneOffsetCode,
  output logic      [7:0]         correlatorBandwidth,
  output logic      [7:0]         postFilterBandwidth,
  output logic      [5:0]         rxLoopSetting,
  output logic      [1:0]         correlatorPhase,
  output logic      [7:0]         wakeLevelLimit,
  // radio control
  output logic                    radioOn,
  output logic                    radioOffState,
  output logic                    wakeLimitIrq
);
  localparam int NREG = 19;

  logic [7:0]  regs_r [NREG];
  logic [7:0]  regs_nxt [NREG];
  logic [7:0]  rd_r, rd_nxt;
  logic [23:0] carrier_r, carrier_nxt;
  logic [11:0] rate_r, rate_nxt, dev_r, dev_nxt;
  logic [7:0]  corrBw_r, corrBw_nxt, post_r, post_nxt, lvl_r, lvl_nxt;
  logic [5:0]  loop_r, loop_nxt;
  logic [1:0]  phase_r, phase_nxt;
  logic [15:0] wakeCnt_r, wakeCnt_nxt;
  rwcr_state_t st_r, st_nxt;
  logic [15:0] unit_r, unit_nxt;
  logic [7:0]  div_r, div_nxt;
  logic [7:0]  dwell_r, dwell_nxt;
  logic        on_r, on_nxt, off_r, off_nxt, irq_r, irq_nxt;
  logic [2:0]  wkSync_r, pre_r, lvlS_r;
  logic [2:0]  wkSync_nxt, pre_nxt, lvlS_nxt;
  logic        wakeEvt;
  logic        inMap;
  logic [4:0]  idx;

  // index from offset; control register sits above the bank
  always_comb
  begin
    inMap = 1'b0;
    idx   = 5'h00;
    if (regAddr >= OFF_WAKE_CNT_LO && regAddr <= OFF_LOOP_PHASE)
    begin
      inMap = 1'b1;
      idx   = 5'(regAddr - OFF_WAKE_CNT_LO);
    end
    else if (regAddr == OFF_WAKE_CTRL)
    begin
      inMap = 1'b1;
      idx   = 5'(NREG - 2);
    end
  end

  // pin synchronisers: stage 0 feeds only stage 1
  always_comb
  begin
    wkSync_nxt = {wkSync_r[1:0], wakeTimerPin};
    pre_nxt    = {pre_r[1:0], preamblePin};
    lvlS_nxt   = {lvlS_r[1:0], levelAbovePin};
    wakeEvt    = wkSync_r[1] & ~wkSync_r[2];
  end

  // register storage and read path
  always_comb
  begin
    for (int i = 0; i < NREG; i++)
      regs_nxt[i] = regs_r[i];
    rd_nxt = 8'h00;
    if (regWrite && inMap)
      regs_nxt[idx] = regWrData;                                   // [RQ14]
    if (regRead && inMap)
    begin
      if (idx == 5'd0)
        rd_nxt = wakeCnt_r[7:0];
      else if (idx == 5'd1)
        rd_nxt = wakeCnt_r[15:8];
      // control offset reads back live status, not the enables written
      else if (idx == 5'(NREG - 2))
        rd_nxt = {6'h00, off_r, on_r};
      else
        rd_nxt = regs_r[idx];                                      // [RQ14]
    end
  end

  // applied settings: multi-byte fields commit together on the top byte write
  always_comb
  begin
    carrier_nxt = carrier_r;
    rate_nxt    = rate_r;
    dev_nxt     = dev_r;
    corrBw_nxt  = regs_r[13];                                      // [RQ8]
    lvl_nxt     = regs_r[6];                                       // [RQ4]
    loop_nxt    = regs_r[16][7:LOOP_LSB];                          // [RQ10]
    phase_nxt   = regs_r[16][PHASE_LSB+1:PHASE_LSB];               // [RQ11]
    // zero is invalid; hold the last legal bandwidth
    post_nxt    = (regs_r[14] != 8'h00) ? regs_r[14] : post_r;     // [RQ9]
    if (regWrite && regAddr == OFF_CARRIER_HI)
      carrier_nxt = {regWrData, regs_r[8], regs_r[7]};             // [RQ5]
    if (regWrite && regAddr == OFF_RATE_DEV_HI)
    begin
      rate_nxt = {regWrData[RATE_HI_LSB+3:RATE_HI_LSB], regs_r[10]};   // [RQ6]
      dev_nxt  = {regWrData[DEV_HI_LSB+3:DEV_HI_LSB], regs_r[12]};     // [RQ7]
    end
  end

  // smart-wake sequencer and wake counter
  always_comb
  begin
    st_nxt      = st_r;
    unit_nxt    = unit_r;
    div_nxt     = div_r;
    dwell_nxt   = dwell_r;
    on_nxt      = on_r;
    off_nxt     = off_r;
    irq_nxt     = 1'b0;
    wakeCnt_nxt = wakeCnt_r;
    if (wakeEvt)
      wakeCnt_nxt = wakeCnt_r + 16'h0001;                          // [RQ12]
    if (regWrite && regAddr == OFF_WAKE_CNT_LO)
      wakeCnt_nxt = {wakeCnt_nxt[15:8], regWrData};                // [RQ13]
    if (regWrite && regAddr == OFF_WAKE_CNT_HI)
      wakeCnt_nxt = {regWrData, wakeCnt_nxt[7:0]};                 // [RQ13]
    case (st_r)
      RW_SLEEP:
      begin
        on_nxt = 1'b0;
        if (wakeEvt && ({regs_r[3], regs_r[2]} < wakeCnt_nxt))    // [RQ1]
        begin
          st_nxt  = RW_OFF;                                        // [RQ12]
          off_nxt = 1'b1;
          irq_nxt = 1'b1;
        end
        else if (wakeEvt && regs_r[17][CTRL_SMART_BIT])
        begin
          st_nxt    = RW_LISTEN;                                   // [RQ2]
          on_nxt    = 1'b1;
          unit_nxt  = 16'h0000;
          div_nxt   = 8'h00;
          dwell_nxt = 8'h00;
        end
      end
      RW_LISTEN:
      begin
        // tick = UNIT_CYCLES * divider mclk cycles
        if (unit_r >= 16'(UNIT_CYCLES - 1))
        begin
          unit_nxt = 16'h0000;
          if (div_r + 8'h01 >= regs_r[5])                          // [RQ3]
          begin
            div_nxt   = 8'h00;
            dwell_nxt = dwell_r + 8'h01;
          end
          else
            div_nxt = div_r + 8'h01;
        end
        else
          unit_nxt = unit_r + 16'h0001;
        if (pre_r[2] || (regs_r[17][CTRL_LEVEL_BIT] && lvlS_r[2]))
          st_nxt = RW_OFF;                                         // [RQ2]
        else if (dwell_r >= regs_r[4])
        begin
          st_nxt = RW_SLEEP;                                       // [RQ2]
          on_nxt = 1'b0;
        end
      end
      RW_OFF:
      begin
        on_nxt  = 1'b0;
        off_nxt = 1'b1;
        // host releases by clearing the smart-wake enable
        if (!regs_r[17][CTRL_SMART_BIT])
        begin
          st_nxt  = RW_SLEEP;
          off_nxt = 1'b0;
        end
      end
      default:
        st_nxt = RW_SLEEP;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NREG; i++)
        regs_r[i] <= RST_BYTE;
      regs_r[5]  <= RST_TICK_DIV;
      regs_r[14] <= RST_POST_FILTER;
      rd_r       <= 8'h00;
      carrier_r  <= 24'h000000;
      rate_r     <= 12'h000;
      dev_r      <= 12'h000;
      corrBw_r   <= 8'h00;
      post_r     <= RST_POST_FILTER;
      lvl_r      <= 8'h00;
      loop_r     <= 6'h00;
      phase_r    <= 2'h0;
      wakeCnt_r  <= 16'h0000;
      st_r       <= RW_SLEEP;
      unit_r     <= 16'h0000;
      div_r      <= 8'h00;
      dwell_r    <= 8'h00;
      on_r       <= 1'b0;
      off_r      <= 1'b0;
      irq_r      <= 1'b0;
      wkSync_r   <= 3'h0;
      pre_r      <= 3'h0;
      lvlS_r     <= 3'h0;
    end
    else
    begin
      regs_r    <= regs_nxt;
      rd_r      <= rd_nxt;
      carrier_r <= carrier_nxt;
      rate_r    <= rate_nxt;
      dev_r     <= dev_nxt;
      corrBw_r  <= corrBw_nxt;
      post_r    <= post_nxt;
      lvl_r     <= lvl_nxt;
      loop_r    <= loop_nxt;
      phase_r   <= phase_nxt;
      wakeCnt_r <= wakeCnt_nxt;
      st_r      <= st_nxt;
      unit_r    <= unit_nxt;
      div_r     <= div_nxt;
      dwell_r   <= dwell_nxt;
      on_r      <= on_nxt;
      off_r     <= off_nxt;
      irq_r     <= irq_nxt;
      wkSync_r  <= wkSync_nxt;
      pre_r     <= pre_nxt;
      lvlS_r    <= lvlS_nxt;
    end
  end

  assign regRdData           = rd_r;
  assign carrierWord         = carrier_r;
  assign rateCode            = rate_r;
  assign toneOffsetCode      = dev_r;
  assign correlatorBandwidth = corrBw_r;
  assign postFilterBandwidth = post_r;
  assign rxLoopSetting       = loop_r;
  assign correlatorPhase     = phase_r;
  assign wakeLevelLimit      = lvl_r;
  assign radioOn             = on_r;
  assign radioOffState       = off_r;
  assign wakeLimitIrq        = irq_r;
endmodule // rwcr_regs
